//--- csw_pkg.sv
// Shared constants and types for the core status and watchdog register bank.
package csw_pkg;

    // Register offsets on the special function register bus.
    localparam logic [7:0] CSW_ADDR_TA   = 8'hC7;
    localparam logic [7:0] CSW_ADDR_PSW  = 8'hD0;
    localparam logic [7:0] CSW_ADDR_WDC  = 8'hD8;
    localparam logic [7:0] CSW_ADDR_ACC  = 8'hE0;
    localparam logic [7:0] CSW_ADDR_EIE  = 8'hE8;
    localparam logic [7:0] CSW_ADDR_B    = 8'hF0;
    localparam logic [7:0] CSW_ADDR_EIP  = 8'hF8;

    // Program status word bit positions.
    localparam int PSW_CY  = 7;
    localparam int PSW_AC  = 6;
    localparam int PSW_F0  = 5;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_OV  = 2;
    localparam int PSW_F1  = 1;
    localparam int PSW_P   = 0;

    // Watchdog control bit positions.
    localparam int WDC_BAUD = 7;
    localparam int WDC_POR  = 6;
    localparam int WDC_WDT_IRQ_FLAG = 3;
    localparam int WDC_WDT_RESET_FLAG = 2;
    localparam int WDC_EWT  = 1;
    localparam int WDC_RWT  = 0;

    // Extended enable and priority layout: bit 4 watchdog, bits 3..0 pins 5..2.
    localparam int IRQ_WDT = 4;
    localparam logic [7:0] EIE_RSVD_ONES = 8'hE0;
    localparam logic [7:0] CSW_RST_BYTE  = 8'h00;

    // Timed access key bytes and window length.
    localparam logic [7:0] TA_KEY_FIRST  = 8'hAA;
    localparam logic [7:0] TA_KEY_SECOND = 8'h55;
    localparam int TA_WINDOW_MCYC = 3;
    localparam int CLKS_PER_MCYC  = 4;
    localparam logic [3:0] TA_WINDOW_CLKS = 4'(TA_WINDOW_MCYC * CLKS_PER_MCYC);

    // Clocks from watchdog timeout to watchdog reset request.
    localparam logic [9:0] WDT_RST_DELAY_CLKS = 10'd512;

    // Flag-affecting operations reported by the execution unit.
    typedef enum logic [3:0] {
        CSW_OP_NONE,
        CSW_OP_ADD,
        CSW_OP_ADDC,
        CSW_OP_SUBB,
        CSW_OP_MULDIV,
        CSW_OP_SETC,
        CSW_OP_CLRC,
        CSW_OP_CARRY
    } csw_op_t;

endpackage : csw_pkg

//--- csw_sfr_bank.sv
// Core status word, operand and watchdog control special function registers.
// What this block does
// - Carry set from ALU carry out; also the one-bit accumulator for bit ops.
// - Nibble carry follows carry between nibbles on add, addc and subb.
// - Two user flags are plain software storage with no side effect.
// - Bank select picks working registers at 00h, 08h, 10h or 18h.
// - Overflow set when carry out of bit six differs from bit seven.
// - Parity flag always shows odd count of ones in primary operand.
// - Baud doubler bit doubles second serial port rate in modes 1-3.
// - Power-up flag set at power-up; cleared only by software write.
// - Watchdog timeout sets irq flag; software clears it.
// - Watchdog reset flag set by watchdog reset when enabled; power-fail clears.
// - Reset flag: 1 after watchdog, 0 after power resets, kept on external.
// - Reset enable cleared by power-on reset only.
// - Writing 1 to restart bit restarts the counter; bit clears itself.
// - Timeout raises irq if enabled; reset follows 512 clocks later if enabled.
// - External reset loads watchdog control with 0x000xx0 pattern.
// - Protected watchdog bits are writable only inside the timed window.
// - Extended enable holds watchdog and pin enables; top three bits read 1.
// - Extended priority holds levels; 0 low, 1 high.
// - Add, addc, subb update three flags; mul and div clear carry, take overflow from the core.
// - Set and clear carry force it; other carry ops write their result.
// - Primary and secondary operand registers are software accessible bytes.
`timescale 1ns/1ns
module csw_sfr_bank
    import csw_pkg::*;
(
    // Clock and external reset.
    input  wire logic             clk,
    input  wire logic             nrst,
    // Other reset causes from the reset controller, one-cycle pulses.
    input  wire logic             pwr_on_rst,
    input  wire logic             pwr_fail_rst,
    input  wire logic             wdt_rst,
    // Register port.
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Execution unit flag and operand updates.
    input  wire csw_pkg::csw_op_t exe_op,
    input  wire logic [7:0]       exe_a,
    input  wire logic [7:0]       exe_b,
    input  wire logic             exe_carry,
    input  wire logic             exe_ov,
    input  wire logic             exe_acc_wr,
    input  wire logic [7:0]       exe_acc_data,
    input  wire logic             exe_b_wr,
    input  wire logic [7:0]       exe_b_data,
    // Status toward the core.
    output logic                  carry_flag,
    output logic                  parity_flag,
    output logic      [4:0]       bank_base,
    output logic      [7:0]       acc_value,
    output logic      [7:0]       b_value,
    output logic                  uart1_baud_x2,
    output logic      [4:0]       irq_enable,
    output logic      [4:0]       irq_level,
    // Watchdog counter side.
    input  wire logic             wdt_timeout,
    output logic                  wdt_counter_restart,
    output logic                  wdt_irq_req,
    output logic                  wdt_reset_req,
    output logic                  ta_window
);
    import csw_pkg::*;

    // Any reset source returns the ordinary registers to their reset values.
    logic any_rst;
    assign any_rst = !nrst || pwr_on_rst || pwr_fail_rst || wdt_rst;

    // Nine-bit sum used for both the full byte and the low nibble.
    function automatic logic [8:0] add_c(input logic [7:0] x, input logic [7:0] y,
                                         input logic cin);
        add_c = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    endfunction : add_c

    // Bus decode.
    logic wr_psw, wr_wdc, wr_acc, wr_eie, wr_b, wr_eip;
    assign wr_psw = reg_wr && (reg_addr == CSW_ADDR_PSW);
    assign wr_wdc = reg_wr && (reg_addr == CSW_ADDR_WDC);
    assign wr_acc = reg_wr && (reg_addr == CSW_ADDR_ACC);
    assign wr_eie = reg_wr && (reg_addr == CSW_ADDR_EIE);
    assign wr_b   = reg_wr && (reg_addr == CSW_ADDR_B);
    assign wr_eip = reg_wr && (reg_addr == CSW_ADDR_EIP);

    // Timed access gate; the window survives nothing but runs on every reset source.
    logic ta_open;
    csw_ta_gate u_ta_gate (
        .clk         (clk),
        .rst_n       (!any_rst),
        .bus_addr    (reg_addr),
        .bus_wdata   (reg_wdata),
        .bus_wr      (reg_wr),
        .window_open (ta_open)
    );
    logic wr_wdc_prot;
    assign wr_wdc_prot = wr_wdc && ta_open;

    // Arithmetic flag results for the add and subtract family.
    logic       cy_r, ac_r, ov_r, f0_r, f1_r;
    logic [1:0] rs_r;
    logic [7:0] opnd_b;
    logic       arith_cin;
    logic [8:0] sum9;
    logic [8:0] nib9;
    logic       is_sub;
    assign is_sub    = (exe_op == CSW_OP_SUBB);
    assign opnd_b    = is_sub ? ~exe_b : exe_b;
    assign arith_cin = (exe_op == CSW_OP_ADD) ? 1'b0 : (is_sub ? !cy_r : cy_r);
    assign sum9      = add_c(exe_a, opnd_b, arith_cin);
    assign nib9      = add_c({4'h0, exe_a[3:0]}, {4'h0, opnd_b[3:0]}, arith_cin);

    logic cy_nxt, ac_nxt, ov_nxt;
    always_comb begin
        cy_nxt = cy_r;
        ac_nxt = ac_r;
        ov_nxt = ov_r;
        // A software write stands except in the flags that the core updates in the same cycle.
        if (wr_psw) begin
            cy_nxt = reg_wdata[PSW_CY];
            ac_nxt = reg_wdata[PSW_AC];
            ov_nxt = reg_wdata[PSW_OV];
        end
        case (exe_op)
            CSW_OP_ADD, CSW_OP_ADDC, CSW_OP_SUBB: begin
                cy_nxt = sum9[8] ^ is_sub;
                ac_nxt = nib9[4] ^ is_sub;
                ov_nxt = (exe_a[7] == opnd_b[7]) && (sum9[7] != exe_a[7]);
            end
            CSW_OP_MULDIV: begin
                cy_nxt = 1'b0;
                ov_nxt = exe_ov;
            end
            CSW_OP_SETC: begin
                cy_nxt = 1'b1;
            end
            CSW_OP_CLRC: begin
                cy_nxt = 1'b0;
            end
            CSW_OP_CARRY: begin
                cy_nxt = exe_carry;
            end
            CSW_OP_NONE: begin
                cy_nxt = cy_nxt;
            end
            default: begin
                cy_nxt = cy_r;
            end
        endcase
    end

    // Status word flags and fields.
    always_ff @(posedge clk) begin
        if (any_rst) begin
            cy_r <= 1'b0;
            ac_r <= 1'b0;
            ov_r <= 1'b0;
        end else begin
            cy_r <= cy_nxt;
            ac_r <= ac_nxt;
            ov_r <= ov_nxt;
        end
    end

    // User flags and bank select are pure storage.
    always_ff @(posedge clk) begin
        if (any_rst) begin
            f0_r <= 1'b0;
            f1_r <= 1'b0;
            rs_r <= 2'b00;
        end else if (wr_psw) begin
            f0_r <= reg_wdata[PSW_F0];
            f1_r <= reg_wdata[PSW_F1];
            rs_r <= {reg_wdata[PSW_RS1], reg_wdata[PSW_RS0]};
        end
    end

    // Operand registers; the core's result wins over a bus write in the same cycle.
    logic [7:0] acc_nxt;
    logic [7:0] b_nxt;
    always_comb begin
        acc_nxt = acc_value;
        b_nxt   = b_value;
        if (exe_acc_wr) begin
            acc_nxt = exe_acc_data;
        end else if (wr_acc) begin
            acc_nxt = reg_wdata;
        end
        if (exe_b_wr) begin
            b_nxt = exe_b_data;
        end else if (wr_b) begin
            b_nxt = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            acc_value   <= CSW_RST_BYTE;
            b_value     <= CSW_RST_BYTE;
            parity_flag <= 1'b0;
        end else begin
            acc_value   <= acc_nxt;
            b_value     <= b_nxt;
            parity_flag <= ^acc_nxt;
        end
    end

    // Carry and bank base mirror the status word so the core reads flops.
    always_ff @(posedge clk) begin
        if (any_rst) begin
            carry_flag <= 1'b0;
            bank_base  <= 5'h00;
        end else begin
            carry_flag <= cy_nxt;
            bank_base  <= wr_psw ? {reg_wdata[PSW_RS1], reg_wdata[PSW_RS0], 3'b000}
                                 : {rs_r, 3'b000};
        end
    end

    // Watchdog control. Bits outside the external-reset pattern keep their values.
    logic por_r, wdt_irq_flag_r, wdt_reset_flag_r, ewt_r;
    always_ff @(posedge clk) begin
        if (any_rst) begin
            uart1_baud_x2 <= 1'b0;
        end else if (wr_wdc) begin
            uart1_baud_x2 <= reg_wdata[WDC_BAUD];
        end
    end

    // Power-up flag: only a protected write clears it.
    always_ff @(posedge clk) begin
        if (pwr_on_rst) begin
            por_r <= 1'b1;
        end else if (wr_wdc_prot) begin
            por_r <= reg_wdata[WDC_POR];
        end
    end

    // Reset enable survives every reset but power-on.
    always_ff @(posedge clk) begin
        if (pwr_on_rst) begin
            ewt_r <= 1'b0;
        end else if (wr_wdc_prot) begin
            ewt_r <= reg_wdata[WDC_EWT];
        end
    end

    // Reset cause flag; external reset leaves it alone and software writes need no window.
    always_ff @(posedge clk) begin
        if (pwr_on_rst || pwr_fail_rst) begin
            wdt_reset_flag_r <= 1'b0;
        end else if (wdt_rst) begin
            wdt_reset_flag_r <= ewt_r;
        end else if (wr_wdc && nrst) begin
            wdt_reset_flag_r <= reg_wdata[WDC_WDT_RESET_FLAG];
        end
    end

    // Timeout flag: a timeout in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (any_rst) begin
            wdt_irq_flag_r <= 1'b0;
        end else if (wdt_timeout) begin
            wdt_irq_flag_r <= 1'b1;
        end else if (wr_wdc_prot) begin
            wdt_irq_flag_r <= reg_wdata[WDC_WDT_IRQ_FLAG];
        end
    end

    // Restart strobe reads back as the one-cycle pulse, so the bit clears itself.
    logic restart_req;
    assign restart_req = wr_wdc_prot && reg_wdata[WDC_RWT];
    always_ff @(posedge clk) begin
        if (any_rst) begin
            wdt_counter_restart <= 1'b0;
        end else begin
            wdt_counter_restart <= restart_req;
        end
    end

    // Delay from timeout to reset request; a restart cancels a pending reset.
    logic [9:0] rst_dly_r;
    always_ff @(posedge clk) begin
        if (any_rst) begin
            rst_dly_r     <= 10'd0;
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= 1'b0;
            if (restart_req) begin
                rst_dly_r <= 10'd0;
            end else if (wdt_timeout && ewt_r && (rst_dly_r == 10'd0)) begin
                rst_dly_r <= WDT_RST_DELAY_CLKS;
            end else if (rst_dly_r != 10'd0) begin
                rst_dly_r <= rst_dly_r - 10'd1;
                if (rst_dly_r == 10'd1) begin
                    wdt_reset_req <= ewt_r;
                end
            end
        end
    end

    // Extended enable and priority registers.
    always_ff @(posedge clk) begin
        if (any_rst) begin
            irq_enable <= 5'h00;
            irq_level  <= 5'h00;
        end else begin
            if (wr_eie) begin
                irq_enable <= reg_wdata[4:0];
            end
            if (wr_eip) begin
                irq_level <= reg_wdata[4:0];
            end
        end
    end

    // Watchdog interrupt request follows the flag while it is enabled.
    always_ff @(posedge clk) begin
        if (any_rst) begin
            wdt_irq_req <= 1'b0;
        end else begin
            wdt_irq_req <= wdt_irq_flag_r && irq_enable[IRQ_WDT];
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            ta_window <= 1'b0;
        end else begin
            ta_window <= ta_open;
        end
    end

    // Read mux; data stands only in the cycle after the strobe, unmapped reads give zero.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            CSW_ADDR_PSW: rd_mux = {cy_r, ac_r, f0_r, rs_r, ov_r, f1_r, parity_flag};
            CSW_ADDR_WDC: rd_mux = {uart1_baud_x2, por_r, 2'b00, wdt_irq_flag_r, wdt_reset_flag_r, ewt_r,
                                    wdt_counter_restart};
            CSW_ADDR_ACC: rd_mux = acc_value;
            CSW_ADDR_EIE: rd_mux = EIE_RSVD_ONES | {3'b000, irq_enable};
            CSW_ADDR_B:   rd_mux = b_value;
            CSW_ADDR_EIP: rd_mux = {3'b000, irq_level};
            default:      rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule : csw_sfr_bank

//--- csw_sfr_bank_chk.sv
// Concurrent checks on the ports of the core status and watchdog bank.
`timescale 1ns/1ns
module csw_sfr_bank_chk
    import csw_pkg::*;
(
    // Clock and reset causes.
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             pwr_on_rst,
    input wire logic             pwr_fail_rst,
    input wire logic             wdt_rst,
    // Register port and core side.
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire csw_pkg::csw_op_t exe_op,
    input wire logic             carry_flag,
    input wire logic             parity_flag,
    input wire logic [4:0]       bank_base,
    input wire logic [7:0]       acc_value,
    input wire logic [4:0]       irq_enable,
    // Watchdog side.
    input wire logic             wdt_timeout,
    input wire logic             wdt_counter_restart,
    input wire logic             wdt_irq_req,
    input wire logic             wdt_reset_req,
    input wire logic             ta_window
);
    import csw_pkg::*;

    logic       rst_any;
    logic [4:0] win_cnt;

    // Every reset cause clears the ordinary registers of the bank, so all of them silence the checks.
    assign rst_any = !nrst || pwr_on_rst || pwr_fail_rst || wdt_rst;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst_any);

    // Length of the open window so far; a window that never closes is caught.
    always_ff @(posedge clk) begin
        if (rst_any || !ta_window) begin
            win_cnt <= 5'h00;
        end else begin
            win_cnt <= win_cnt + 5'h01;
        end
    end

    property p_parity; parity_flag == ^acc_value; endproperty
    a_parity: assert property (p_parity) else $error("parity flag off");
    property p_carry_set; exe_op == CSW_OP_SETC |=> carry_flag; endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry not set");
    property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_bank;
        reg_wr && reg_addr == CSW_ADDR_PSW && exe_op == CSW_OP_NONE
            |=> bank_base == 5'($past(reg_wdata) & 8'h18);
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong");
    property p_restart_cause;
        wdt_counter_restart |-> $past(reg_wr) && $past(reg_addr) == CSW_ADDR_WDC
            && $past(reg_wdata[WDC_RWT]);
    endproperty
    a_restart_cause: assert property (p_restart_cause) else $error("stray restart");
    property p_restart_pulse; wdt_counter_restart |=> !wdt_counter_restart; endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
    property p_irq_req; wdt_irq_req |-> $past(irq_enable[IRQ_WDT]); endproperty
    a_irq_req: assert property (p_irq_req) else $error("irq without enable");
    property p_reset_delay; wdt_reset_req |-> $past(wdt_timeout, 513); endproperty
    a_reset_delay: assert property (p_reset_delay) else $error("reset delay wrong");
    property p_win_cause;
        $rose(ta_window) |-> $past(reg_wr, 2) && $past(reg_wdata, 2) == TA_KEY_SECOND;
    endproperty
    a_win_cause: assert property (p_win_cause) else $error("window without key");
    property p_win_len; ta_window |-> win_cnt < 5'h0C; endproperty
    a_win_len: assert property (p_win_len) else $error("window too long");

    c_reset: cover property (wdt_reset_req);
    c_restart: cover property (wdt_counter_restart);
    c_window: cover property ($rose(ta_window));
endmodule : csw_sfr_bank_chk

//--- csw_sfr_bank_tb_top.sv
// Self-checking bench for the core status and watchdog register bank.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module csw_sfr_bank_tb_top;
    import csw_pkg::*;
    logic       clk, nrst, pwr_on_rst, pwr_fail_rst, wdt_rst, run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, exe_a, exe_b, acc_value, b_value;
    logic       reg_wr, reg_rd, exe_carry, exe_ov, exe_acc_wr, exe_b_wr;
    logic [7:0] exe_acc_data, exe_b_data;
    logic       carry_flag, parity_flag, uart1_baud_x2, wdt_timeout;
    logic       wdt_counter_restart, wdt_irq_req, wdt_reset_req, ta_window;
    logic [4:0] bank_base, irq_enable, irq_level;
    csw_op_t    exe_op;
    int         error_cnt, compares;

    csw_sfr_bank i_csw_sfr_bank (.clk, .nrst, .pwr_on_rst, .pwr_fail_rst, .wdt_rst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .exe_op, .exe_a, .exe_b,
        .exe_carry, .exe_ov, .exe_acc_wr, .exe_acc_data, .exe_b_wr, .exe_b_data,
        .carry_flag, .parity_flag, .bank_base, .acc_value, .b_value, .uart1_baud_x2,
        .irq_enable, .irq_level, .wdt_timeout, .wdt_counter_restart, .wdt_irq_req,
        .wdt_reset_req, .ta_window);
    csw_wdt_model #(.PERIOD(40)) i_csw_wdt_model (.clk, .run,
        .restart(wdt_counter_restart), .timeout(wdt_timeout));

    // Clock at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrap_up;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // Write strobe is left high so back-to-back writes need no gap.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so look at mid-cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        `CHK(nm, exp, reg_rdata)
        @(posedge clk);
    endtask : rd

    // One-cycle reset cause; the vector is {nrst, pwr_on_rst, pwr_fail_rst, wdt_rst}.
    task automatic pulse(input logic [3:0] v);
        reg_wr <= 1'b0;
        {nrst, pwr_on_rst, pwr_fail_rst, wdt_rst} <= v;
        @(posedge clk);
        {nrst, pwr_on_rst, pwr_fail_rst, wdt_rst} <= 4'h8;
        @(posedge clk);
    endtask : pulse

    task automatic t_regs;
        rd(CSW_ADDR_WDC, 8'h40, "wdc_por");
        rd(CSW_ADDR_EIE, 8'hE0, "eie_rst");
        wr(CSW_ADDR_EIE, 8'hFF);
        wr(CSW_ADDR_EIP, 8'hFF);
        wr(8'h00, 8'h5A);
        wr(CSW_ADDR_ACC, 8'h07);
        wr(CSW_ADDR_B, 8'hA5);
        rd(CSW_ADDR_EIP, 8'h1F, "eip");
        `CHK("levels", 5'h1F, irq_level)
        `CHK("enables", 5'h1F, irq_enable)
        rd(8'h00, 8'h00, "unmapped");
        rd(CSW_ADDR_B, 8'hA5, "b_reg");
        for (int i = 0; i < 4; i++) begin
            wr(CSW_ADDR_PSW, 8'(i * 8) | 8'h22);
            rd(CSW_ADDR_PSW, 8'(i * 8) | 8'h23, "psw_bank");
            `CHK("bank_base", 5'(i * 8), bank_base)
        end
    endtask : t_regs

    task automatic t_flags;
        wr(CSW_ADDR_PSW, 8'h00);
        wr(CSW_ADDR_ACC, 8'h00);
        reg_wr <= 1'b0;
        exe_op <= CSW_OP_ADD;
        @(posedge clk);
        exe_op <= CSW_OP_MULDIV;
        rd(CSW_ADDR_PSW, 8'hC4, "add_flags");
        exe_op <= CSW_OP_NONE;
        rd(CSW_ADDR_PSW, 8'h44, "muldiv_flags");
        for (int i = 0; i < 3; i++) begin
            exe_op <= (i == 0) ? CSW_OP_SETC : (i == 1) ? CSW_OP_CLRC : CSW_OP_CARRY;
            @(posedge clk);
            exe_op <= CSW_OP_NONE;
            @(negedge clk);
            `CHK("carry_flag", i != 1, carry_flag)
            @(posedge clk);
        end
        // Carry is 1 here, so ADDC adds it in and SUBB then borrows it.
        exe_b <= 8'h77;
        exe_op <= CSW_OP_ADDC;
        @(posedge clk);
        exe_op <= CSW_OP_SUBB;
        rd(CSW_ADDR_PSW, 8'hC0, "addc_flags");
        exe_op <= CSW_OP_NONE;
        rd(CSW_ADDR_PSW, 8'h04, "subb_flags");
        // The core's accumulator write wins over a bus write in the same cycle; B takes a core write alone.
        exe_acc_wr <= 1'b1;
        exe_b_wr <= 1'b1;
        exe_acc_data <= 8'h01;
        exe_b_data <= 8'h3C;
        wr(CSW_ADDR_ACC, 8'hFF);
        exe_acc_wr <= 1'b0;
        exe_b_wr <= 1'b0;
        rd(CSW_ADDR_ACC, 8'h01, "acc_core");
        `CHK("acc_value", 8'h01, acc_value)
        `CHK("b_value", 8'h3C, b_value)
        `CHK("parity_flag", 1'b1, parity_flag)
    endtask : t_flags

    task automatic t_protect;
        wr(CSW_ADDR_WDC, 8'h8F);
        rd(CSW_ADDR_WDC, 8'hC4, "wdc_unkeyed");
        `CHK("baud_x2", 1'b1, uart1_baud_x2)
        // Key bytes back to back, then the protected write at once.
        wr(CSW_ADDR_TA, TA_KEY_FIRST);
        wr(CSW_ADDR_TA, TA_KEY_SECOND);
        wr(CSW_ADDR_WDC, 8'h03);
        reg_wr <= 1'b0;
        @(negedge clk);
        `CHK("restart", 1'b1, wdt_counter_restart)
        `CHK("ta_window", 1'b1, ta_window)
        @(posedge clk);
        rd(CSW_ADDR_WDC, 8'h02, "wdc_keyed");
        repeat (12) @(posedge clk);
        wr(CSW_ADDR_WDC, 8'h00);
        rd(CSW_ADDR_WDC, 8'h02, "wdc_closed");
        `CHK("ta_window", 1'b0, ta_window)
    endtask : t_protect

    task automatic t_wdog;
        int n;
        n = 0;
        run <= 1'b1;
        while (!wdt_reset_req && n < 700) begin
            @(posedge clk);
            n++;
            if (n == 45) begin
                `CHK("irq_req", 1'b1, wdt_irq_req)
                rd(CSW_ADDR_WDC, 8'h0A, "wdc_timeout");
            end
        end
        `CHK("reset_req", 1'b1, wdt_reset_req)
        run <= 1'b0;
        pulse(4'h9);
        rd(CSW_ADDR_WDC, 8'h06, "wdc_wdt_rst");
        wr(CSW_ADDR_WDC, 8'h84);
        pulse(4'h0);
        rd(CSW_ADDR_WDC, 8'h06, "wdc_ext_rst");
        pulse(4'hA);
        rd(CSW_ADDR_WDC, 8'h02, "wdc_pfail");
        pulse(4'hC);
        rd(CSW_ADDR_WDC, 8'h40, "wdc_pon");
    endtask : t_wdog

    // Power-on and external reset together define every flag.
    initial begin
        {nrst, pwr_fail_rst, wdt_rst, run, reg_wr, reg_rd} = '0;
        {reg_addr, reg_wdata, exe_acc_data, exe_b_data} = '0;
        {exe_acc_wr, exe_b_wr, exe_ov, exe_carry} = 4'h3;
        {exe_a, exe_b} = 16'h8888;
        exe_op = CSW_OP_NONE;
        pwr_on_rst = 1'b1;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        pwr_on_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_flags();
        t_protect();
        t_wdog();
        wrap_up();
    end

    // Hang guard.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule : csw_sfr_bank_tb_top

bind csw_sfr_bank csw_sfr_bank_chk i_csw_sfr_bank_chk (.clk, .nrst, .pwr_on_rst,
    .pwr_fail_rst, .wdt_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .exe_op, .carry_flag, .parity_flag, .bank_base, .acc_value, .irq_enable,
    .wdt_timeout, .wdt_counter_restart, .wdt_irq_req, .wdt_reset_req, .ta_window);

//--- csw_ta_gate.sv
// Timed access key detector and protected-write window timer.
`timescale 1ns/1ns
module csw_ta_gate
    import csw_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register bus write side.
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    // Window state.
    output logic            window_open
);
    import csw_pkg::*;

    logic       armed_r;
    logic [3:0] win_cnt_r;
    logic [3:0] win_cnt_nxt;
    logic       key_write;

    assign key_write = bus_wr && (bus_addr == CSW_ADDR_TA);

    // The first key arms; any other write in between disarms, so the pair must be adjacent.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (bus_wr) begin
            armed_r <= key_write && (bus_wdata == TA_KEY_FIRST);
        end
    end

    // Window counts down from the second key write.
    always_comb begin
        win_cnt_nxt = win_cnt_r;
        if (key_write && armed_r && (bus_wdata == TA_KEY_SECOND)) begin
            win_cnt_nxt = TA_WINDOW_CLKS;
        end else if (win_cnt_r != 4'h0) begin
            win_cnt_nxt = win_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_cnt_r   <= 4'h0;
            window_open <= 1'b0;
        end else begin
            win_cnt_r   <= win_cnt_nxt;
            window_open <= (win_cnt_nxt != 4'h0);
        end
    end

endmodule : csw_ta_gate

//--- csw_wdt_model.sv
// Behavioural watchdog counter standing beside the register bank.
`timescale 1ns/1ns
module csw_wdt_model #(
    parameter int PERIOD = 40
) (
    // Clock and run control.
    input  wire logic clk,
    input  wire logic run,
    input  wire logic restart,
    // Timeout strobe toward the bank.
    output logic      timeout
);
    int cnt;

    // Free-running period; a restart pulse brings the count back to zero.
    always_ff @(posedge clk) begin
        if (!run || restart) begin
            cnt <= 0;
            timeout <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            timeout <= (cnt == PERIOD - 1);
        end
    end
endmodule : csw_wdt_model
